// ### logic/pin_configured_adc_readout.sv
// The register addresses and the Wishbone slave port were left to the implementer.
`timescale 1ns/10ps
`include "adc_readout_consts.svh"

module pin_configured_adc_readout
    import adc_readout_pkg::*;
#(
    parameter int ADR_W = 4
)
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // Static select pins
    input  wire logic              powerdown_reset_in,
    input  wire logic              clock_source_select,
    input  wire logic              input_pair_select,
    input  wire logic              temp_select,
    input  wire logic              gain_select_lo,
    input  wire logic              gain_select_hi,
    input  wire logic              rate_select_lo,
    input  wire logic              rate_select_hi,
    // Serial link
    input  wire logic              serial_clk,
    output logic                   dout_rdy,
    output logic                   dout_rdy_oe,
    // Filter side
    input  wire logic              conv_start,
    input  wire logic              conv_valid,
    input  wire logic [23:0]       conv_data,
    output logic                   filter_reset,
    output logic                   clk_src_internal,
    output input_src_e             input_src,
    output code2_t                 gain_code,
    output code2_t                 rate_code,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Interrupt
    output logic                   irq
);

    localparam int NPIN = 9;
    localparam logic [4:0] LAST_BIT = 5'(`WORD_BITS);

    // Pin synchronisers
    logic [NPIN-1:0]        pin_meta_q;
    logic [NPIN-1:0]        pin_q;
    logic                   sclk_prev_q;
    wire  [NPIN-1:0]        pin_raw;

    assign pin_raw = {powerdown_reset_in, serial_clk, clock_source_select,
                      input_pair_select, temp_select, gain_select_hi,
                      gain_select_lo, rate_select_hi, rate_select_lo};

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            // Serial clock idles high; a low reset value would fake an edge
            pin_meta_q  <= 9'h080;
            pin_q       <= 9'h080;
            sclk_prev_q <= 1'b1;
        end
        else
        begin
            pin_meta_q  <= pin_raw;
            pin_q       <= pin_meta_q;
            sclk_prev_q <= pin_q[7];
        end
    end

    wire pd_pin    = pin_q[8];
    wire sclk_s    = pin_q[7];
    // Edges only, so bursts and free-running clocks look alike
    wire sclk_fall = sclk_prev_q & ~sclk_s;
    wire sclk_rise = ~sclk_prev_q & sclk_s;

    // Power-down filter; glitches shorter than the minimum are ignored
    logic [2:0]             pd_cnt_q;
    logic                   pd_act_q;
    wire  pd_cnt_full = (pd_cnt_q == 3'(`PD_MIN_CYC - 1));

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pd_cnt_q <= '0;
            pd_act_q <= 1'b1;
        end
        else
        begin
            if (!pd_pin)
                pd_cnt_q <= '0;
            else if (!pd_cnt_full)
                pd_cnt_q <= pd_cnt_q + 3'd1;
            pd_act_q <= pd_pin ? (pd_act_q | pd_cnt_full) : 1'b0;
        end
    end

    wire pd_now = pd_pin & (pd_act_q | pd_cnt_full);
    wire pd_exit = pd_act_q & ~pd_pin;

    // Conversion configuration, sampled at conversion start
    input_src_e             src_d;
    assign src_d = pin_q[4] ? SRC_TEMP
                 : (pin_q[5] ? SRC_PAIR_B : SRC_PAIR_A);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_src_internal <= 1'b0;
            input_src        <= SRC_PAIR_A;
            gain_code        <= '0;
            rate_code        <= '0;
            filter_reset     <= 1'b1;
        end
        else
        begin
            filter_reset <= pd_now;
            if (conv_start && !pd_now)
            begin
                clk_src_internal <= pin_q[6];
                input_src        <= src_d;
                gain_code        <= pin_q[3:2];
                rate_code        <= pin_q[1:0];
            end
        end
    end

    // Serial shifter
    ser_state_e             state_q;
    ser_state_e             state_d;
    logic [23:0]            word_q;
    logic [4:0]             bit_cnt_q;
    logic [1:0]             gap_cnt_q;
    logic [23:0]            result_q;

    wire new_word   = conv_valid & ~pd_now;
    wire unread     = (state_q == S_SHIFT) && (bit_cnt_q == 5'd0);
    wire gap_done   = (gap_cnt_q == 2'(`RDY_GAP_CYC - 1));
    wire shift_bit  = (state_q == S_SHIFT) & sclk_fall;
    wire read_end   = (state_q == S_LAST) & sclk_rise;
    wire next_bit   = word_q[5'd23 - bit_cnt_q];

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_PD:    state_d = new_word ? S_SHIFT : S_IDLE;
            S_IDLE:  if (new_word) state_d = S_SHIFT;
            S_GAP:   if (gap_done) state_d = S_SHIFT;
            S_SHIFT:
            begin
                if (new_word)
                    state_d = unread ? S_GAP : S_SHIFT;
                else if (shift_bit && bit_cnt_q == LAST_BIT - 5'd1)
                    state_d = S_LAST;
            end
            S_LAST:
            begin
                if (new_word)
                    state_d = S_SHIFT;
                else if (sclk_rise)
                    state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
        if (pd_now)
            state_d = S_PD;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q     <= S_PD;
            word_q      <= '0;
            bit_cnt_q   <= '0;
            gap_cnt_q   <= '0;
            dout_rdy    <= 1'b1;
            dout_rdy_oe <= 1'b0;
            result_q    <= '0;
        end
        else
        begin
            state_q     <= state_d;
            dout_rdy_oe <= ~pd_now;
            gap_cnt_q   <= (state_q == S_GAP) ? gap_cnt_q + 2'd1 : 2'd0;
            if (pd_now)
            begin
                word_q    <= '0;
                bit_cnt_q <= '0;
                dout_rdy  <= 1'b1;
            end
            else if (new_word)
            begin
                word_q    <= conv_data;
                result_q  <= conv_data;
                bit_cnt_q <= '0;
                // Unread word: pulse ready high before the new one
                dout_rdy  <= unread ? 1'b1 : 1'b0;
            end
            else if (state_q == S_GAP && gap_done)
                dout_rdy <= 1'b0;
            else if (shift_bit)
            begin
                dout_rdy  <= next_bit;
                bit_cnt_q <= bit_cnt_q + 5'd1;
            end
            else if (read_end)
                dout_rdy <= 1'b1;
        end
    end

    // Wishbone registers
    logic [`EV_BITS-1:0]    status_q;
    logic [`EV_BITS-1:0]    mask_q;
    wire  [`EV_BITS-1:0]    ev_set;
    wire  [`EV_BITS-1:0]    ev_clr;
    wire  wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire  wb_wr    = wb_req & wb_we_i & wb_sel_i[0];
    wire  sel_stat = (wb_adr_i == `REG_STATUS);
    wire  sel_mask = (wb_adr_i == `REG_MASK);
    wire  sel_st   = (wb_adr_i == `REG_STATE);
    wire  sel_res  = (wb_adr_i == `REG_RESULT);
    wire  [31:0] state_word = {20'h0, pin_q[6:0], pd_act_q,
                               dout_rdy, 3'(state_q)};
    wire  [31:0] rd_mux =
          sel_stat ? {28'h0, status_q}
        : sel_mask ? {28'h0, mask_q}
        : sel_st   ? state_word
        : sel_res  ? {8'h00, result_q}
        : 32'h0000_0000;

    assign ev_set[`EV_NEW_RESULT] = new_word;
    assign ev_set[`EV_WORD_READ]  = read_end & ~new_word;
    assign ev_set[`EV_OVERRUN]    = new_word & unread;
    assign ev_set[`EV_PD_EXIT]    = pd_exit;
    assign ev_clr = (wb_wr && sel_stat) ? wb_dat_i[`EV_BITS-1:0] : '0;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            status_q <= '0;
            mask_q   <= `MASK_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            irq      <= 1'b0;
        end
        else
        begin
            // Set wins over a clear in the same cycle
            status_q <= (status_q & ~ev_clr) | ev_set;
            if (wb_wr && sel_mask)
                mask_q <= wb_dat_i[`EV_BITS-1:0];
            wb_ack_o <= wb_req;
            wb_dat_o <= wb_req ? rd_mux : 32'h0000_0000;
            irq      <= |(status_q & mask_q);
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    pd_float_a: assert property (
        pd_now |=> !dout_rdy_oe)
        else $error("line not floated in power-down");
    pd_reset_a: assert property (
        pd_now |=> state_q == S_PD && bit_cnt_q == 5'd0 && filter_reset)
        else $error("power-down did not reset logic");
    pd_glitch_a: assert property (
        $rose(pd_pin) |-> !pd_now ##1 !pd_now)
        else $error("short power-down pulse acted");
    fall_launch_a: assert property (
        shift_bit && !new_word && !pd_now |=> dout_rdy == $past(next_bit))
        else $error("wrong bit launched on falling edge");
    rise_hold_a: assert property (
        state_q == S_SHIFT && !sclk_fall && !new_word && !pd_now
        |=> $stable(dout_rdy))
        else $error("data changed without falling edge");
    ready_low_a: assert property (
        new_word && state_q == S_IDLE |=> !dout_rdy && state_q == S_SHIFT)
        else $error("ready not low on new result");
    unread_gap_a: assert property (
        new_word && unread |=> dout_rdy [*2] ##1 !dout_rdy)
        else $error("ready not high before update");
    read_once_a: assert property (
        read_end && !new_word && !pd_now
        |=> state_q == S_IDLE && dout_rdy)
        else $error("ready not high after read");
    restart_a: assert property (
        new_word |=> bit_cnt_q == 5'd0)
        else $error("serial state not restarted");
    cfg_latch_a: assert property (
        conv_start && !pd_now |=> gain_code == $past(pin_q[3:2])
        && rate_code == $past(pin_q[1:0]) && input_src == $past(src_d)
        && clk_src_internal == $past(pin_q[6]))
        else $error("configuration not taken at start");
    cfg_hold_a: assert property (
        !conv_start |=> $stable(gain_code) && $stable(input_src))
        else $error("configuration changed mid conversion");
    irq_level_a: assert property (
        |(status_q & mask_q) |=> irq)
        else $error("interrupt not raised");
    oe_return_a: assert property (
        !rst && !pd_now |=> dout_rdy_oe)
        else $error("line not driven after power-down");
    filter_release_a: assert property (
        !rst && !pd_now |=> !filter_reset)
        else $error("filter held in reset");
    ready_idle_a: assert property (
        state_q == S_IDLE |-> dout_rdy)
        else $error("ready low while idle");
    shift_count_a: assert property (
        state_q == S_SHIFT |-> bit_cnt_q < LAST_BIT)
        else $error("bit count past word end");
    result_event_a: assert property (
        new_word |=> status_q[`EV_NEW_RESULT])
        else $error("new result not flagged");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    rdata_idle_a: assert property (
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    irq_clear_a: assert property (
        !(|(status_q & mask_q)) |=> !irq)
        else $error("interrupt without cause");

    full_read_c: cover property (read_end ##1 state_q == S_IDLE);
    overrun_c: cover property (new_word && unread);
    pd_cycle_c: cover property (pd_now ##[1:20] pd_exit);
    irq_c: cover property ($rose(irq));
    gap_c: cover property (state_q == S_GAP ##1 state_q == S_SHIFT);

endmodule

// ### logic/adc_readout_consts.svh
// How it works
// - A new output bit is launched on each falling edge of the serial clock.
// - While power-down is high the data/ready line is floated.
// - Power-down resets the serial state, control logic and filter.
// - Clock select low picks the external clock, high the 4.92 MHz oscillator.
// - Pair select low routes the first input pair, high the second pair.
// - Temperature select high routes the sensor, low the selected pair.
// - The two gain pins form a two-bit code for the amplifier gain.
// - The serial clock may run continuously or in separate bursts.
// - Ready goes low at a new result and goes high before an unread update.
// - A word is read once and ready returns high after it is read.
// - The serial state restarts whenever a new result arrives.
// - The two rate pins form a two-bit code for the output data rate.
`ifndef ADC_READOUT_CONSTS_SVH
`define ADC_READOUT_CONSTS_SVH

`define CORE_CLK_NS      40
`define PD_MIN_NS        100
`define PD_MIN_CYC       ((`PD_MIN_NS + `CORE_CLK_NS - 1) / `CORE_CLK_NS)
`define RDY_GAP_CYC      2
`define WORD_BITS        24

`define REG_STATUS       4'h0
`define REG_MASK         4'h4
`define REG_STATE        4'h8
`define REG_RESULT       4'hC

`define EV_NEW_RESULT    0
`define EV_WORD_READ     1
`define EV_OVERRUN       2
`define EV_PD_EXIT       3
`define EV_BITS          4
`define MASK_RESET       4'h0

`endif

// ### logic/adc_readout_pkg.sv
package adc_readout_pkg;

    typedef enum logic [2:0]
    {
        S_PD,
        S_IDLE,
        S_GAP,
        S_SHIFT,
        S_LAST
    } ser_state_e;

    typedef enum logic [1:0]
    {
        SRC_PAIR_A,
        SRC_PAIR_B,
        SRC_TEMP
    } input_src_e;

    typedef logic [1:0] code2_t;

endpackage

// ### sim/host_reader.sv
`timescale 1ns/10ps

module host_reader
(
    // Serial link
    output logic       serial_clk,
    input  wire logic  dout_rdy,
    input  wire logic  dout_rdy_oe
);
    logic  line;

    // A floated line shows the opposite level, so stale bits never match
    assign line = dout_rdy_oe ? dout_rdy : ~dout_rdy;

    initial serial_clk = 1'b1;

    // Clock stands high between bursts; bits are taken on the rising edge
    task automatic read_bits(input int n, inout logic [23:0] w);
        #7;
        repeat (n)
        begin
            #160 serial_clk = 1'b0;
            #160 serial_clk = 1'b1;
            w = {w[22:0], line};
        end
        #33;
    endtask
endmodule

// ### sim/pin_configured_adc_readout_test.sv
`timescale 1ns/10ps
`include "adc_readout_consts.svh"

module pin_configured_adc_readout_test
    import adc_readout_pkg::*;
;
    logic         core_clk;
    logic         rst;
    logic         powerdown_reset_in;
    logic [6:0]   pins;
    logic         serial_clk;
    logic         dout_rdy;
    logic         dout_rdy_oe;
    logic         conv_start;
    logic         conv_valid;
    logic [23:0]  conv_data;
    logic         filter_reset;
    logic         clk_src_internal;
    input_src_e   input_src;
    code2_t       gain_code;
    code2_t       rate_code;
    logic         wb_cyc_i;
    logic         wb_stb_i;
    logic         wb_we_i;
    logic [3:0]   wb_adr_i;
    logic [3:0]   wb_sel_i;
    logic [31:0]  wb_dat_i;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic         irq;
    logic [31:0]  q;
    logic [23:0]  w;
    int           error_cnt;
    int           cmp_count;

    pin_configured_adc_readout pin_configured_adc_readout_inst
    (
        .core_clk(core_clk), .rst(rst),
        .powerdown_reset_in(powerdown_reset_in),
        .clock_source_select(pins[6]), .input_pair_select(pins[5]),
        .temp_select(pins[4]), .gain_select_hi(pins[3]),
        .gain_select_lo(pins[2]), .rate_select_hi(pins[1]),
        .rate_select_lo(pins[0]), .serial_clk(serial_clk),
        .dout_rdy(dout_rdy), .dout_rdy_oe(dout_rdy_oe),
        .conv_start(conv_start), .conv_valid(conv_valid),
        .conv_data(conv_data), .filter_reset(filter_reset),
        .clk_src_internal(clk_src_internal), .input_src(input_src),
        .gain_code(gain_code), .rate_code(rate_code),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq)
    );

    host_reader host_reader_inst
    (
        .serial_clk(serial_clk), .dout_rdy(dout_rdy),
        .dout_rdy_oe(dout_rdy_oe)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Classic single cycle; the request is held until ack is sampled
    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge core_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 20);
        r = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
        if (wb_ack_o !== 1'b1)
        begin
            check(0, 1);
            close_out();
        end
    endtask

    task automatic new_word(input logic [23:0] d);
        @(posedge core_clk);
        conv_valid <= 1'b1;
        conv_data <= d;
        @(posedge core_clk);
        conv_valid <= 1'b0;
    endtask

    task automatic t_config;
        logic [6:0] tbl [4] = '{7'h45, 7'h2A, 7'h1F, 7'h00};
        input_src_e src;
        foreach (tbl[i])
        begin
            pins <= tbl[i];
            repeat (4) @(posedge core_clk);
            conv_start <= 1'b1;
            @(posedge core_clk);
            conv_start <= 1'b0;
            repeat (2) @(negedge core_clk);
            src = tbl[i][4] ? SRC_TEMP : tbl[i][5] ? SRC_PAIR_B : SRC_PAIR_A;
            check(clk_src_internal, tbl[i][6]);
            check(input_src, src);
            check(gain_code, tbl[i][3:2]);
            check(rate_code, tbl[i][1:0]);
            wb(1'b0, `REG_STATE, 0, q);
            check(q[11:5], tbl[i]);
        end
        // Pins moved without a conversion start must not reach the codes
        pins <= 7'h7F;
        repeat (6) @(negedge core_clk);
        check({clk_src_internal, gain_code, rate_code}, 5'h00);
        $display("config test done");
    endtask

    task automatic t_read;
        new_word(24'hA5C31E);
        @(negedge core_clk);
        check(dout_rdy, 1'b0);
        w = '0;
        host_reader_inst.read_bits(12, w);
        repeat (5) @(posedge core_clk);
        host_reader_inst.read_bits(12, w);
        check(w, 24'hA5C31E);
        repeat (4) @(negedge core_clk);
        check(dout_rdy, 1'b1);
        wb(1'b0, `REG_STATUS, 0, q);
        check(q, 32'h3);
        wb(1'b1, `REG_MASK, 32'h2, q);
        repeat (3) @(negedge core_clk);
        check(irq, 1'b1);
        wb(1'b1, `REG_STATUS, 32'h3, q);
        repeat (3) @(negedge core_clk);
        check(irq, 1'b0);
        $display("read test done");
    endtask

    task automatic t_overrun;
        new_word(24'h123456);
        new_word(24'h00FFFF);
        @(negedge core_clk);
        check(dout_rdy, 1'b1);
        repeat (4) @(negedge core_clk);
        check(dout_rdy, 1'b0);
        w = '0;
        host_reader_inst.read_bits(24, w);
        check(w, 24'h00FFFF);
        wb(1'b0, `REG_STATUS, 0, q);
        check(q[2], 1'b1);
        wb(1'b1, `REG_STATUS, 32'hF, q);
        $display("overrun test done");
    endtask

    task automatic t_powerdown;
        // Two cycles are 80 ns, below the minimum, so nothing may happen
        powerdown_reset_in <= 1'b1;
        repeat (2) @(posedge core_clk);
        powerdown_reset_in <= 1'b0;
        repeat (8) @(negedge core_clk);
        check(dout_rdy_oe, 1'b1);
        new_word(24'h5A5A5A);
        powerdown_reset_in <= 1'b1;
        repeat (10) @(negedge core_clk);
        check(dout_rdy_oe, 1'b0);
        check(filter_reset, 1'b1);
        @(posedge core_clk);
        powerdown_reset_in <= 1'b0;
        repeat (10) @(negedge core_clk);
        check({dout_rdy_oe, dout_rdy, filter_reset}, 3'b110);
        $display("power-down test done");
    endtask

    task automatic t_regs;
        // Logic leaves power-down after reset, which flags the exit event
        wb(1'b0, `REG_STATUS, 0, q);
        check(q, 32'h8);
        wb(1'b1, `REG_STATUS, 32'hF, q);
        wb(1'b0, `REG_STATUS, 0, q);
        check(q, 32'h0);
        wb(1'b0, `REG_MASK, 0, q);
        check(q, 32'h0);
        wb(1'b0, 4'h2, 0, q);
        check(q, 32'h0);
        wb(1'b0, `REG_STATE, 0, q);
        check(q[4:0], 5'h09);
        $display("register test done");
    endtask

    initial
    begin
        {rst, powerdown_reset_in, pins, conv_start, conv_valid} = 11'h400;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} = '0;
        {conv_data, wb_dat_i, error_cnt, cmp_count} = '0;
        wb_sel_i = 4'hF;
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        repeat (10) @(posedge core_clk);
        t_regs();
        t_config();
        t_read();
        t_overrun();
        t_powerdown();
        close_out();
    end
endmodule
